/* File: gcc_defs.vh */
`ifndef GCC_DEFS_VH
`define GCC_DEFS_VH

// apb register byte offsets
`define GCC_OFS_CTRL      12'h000
`define GCC_OFS_GAIN      12'h004
`define GCC_OFS_GPO       12'h008
`define GCC_OFS_STATUS    12'h00C

// control register fields
`define GCC_CTRL_ZC_BIT   0
`define GCC_CTRL_RESET    1'h0

// status register field positions
`define GCC_ST_GAIN_LSB   0
`define GCC_ST_PEND_BIT   8
`define GCC_ST_ADDR_LSB   12

// gain codes: zero is minimum, 8 to 63 are one-step codes
`define GCC_GAIN_MIN      6'h00
`define GCC_GAIN_STEP_LO  6'h08
`define GCC_GAIN_RESET    6'h00
`define GCC_GPO_RESET     4'h0

// serial frame layout, 16 bits, msb first
`define GCC_FRAME_BITS    5'h10
`define GCC_FR_ADDR_MSB   15
`define GCC_FR_ADDR_LSB   13
`define GCC_FR_CMD_MSB    12
`define GCC_FR_CMD_LSB    11
`define GCC_CMD_GAIN      2'h0
`define GCC_CMD_GPO       2'h1

`endif

/* File: gcc_spi_rx.v */
`timescale 1ns/100ps
`default_nettype none
`include "gcc_defs.vh"

module gcc_spi_rx (
    input  wire        clk,
    input  wire        rst,
    input  wire        clamp,
    input  wire        sclk_pin,
    input  wire        cs_n_pin,
    input  wire        din_pin,
    output reg         frame_valid_reg,
    output reg  [15:0] frame_word_reg
);

    reg  [2:0]  sclk_sync;
    reg  [2:0]  cs_n_sync;
    reg  [2:0]  din_sync;
    reg         sclk_f_reg;
    reg         cs_n_f_reg;
    reg         din_f_reg;
    reg  [15:0] shift_reg;
    reg  [4:0]  count_reg;

    // three-stage synchronisers; only stages two and three are looked at
    always @(posedge clk)
    begin
        sclk_sync <= {sclk_sync[1:0], sclk_pin};
        cs_n_sync <= {cs_n_sync[1:0], cs_n_pin};
        din_sync  <= {din_sync[1:0], din_pin};
    end

    // a level counts only once stages two and three agree
    always @(posedge clk)
    begin
        if (rst)
        begin
            sclk_f_reg <= 1'b0;
            cs_n_f_reg <= 1'b1;
            din_f_reg  <= 1'b0;
        end
        else
        begin
            if (sclk_sync[1] == sclk_sync[2])
                sclk_f_reg <= sclk_sync[2];
            if (cs_n_sync[1] == cs_n_sync[2])
                cs_n_f_reg <= cs_n_sync[2];
            if (din_sync[1] == din_sync[2])
                din_f_reg <= din_sync[2];
        end
    end

    wire sclk_rise = (sclk_sync[2] == sclk_sync[1]) & sclk_sync[2] &
                     ~sclk_f_reg;
    wire cs_rise   = (cs_n_sync[2] == cs_n_sync[1]) & cs_n_sync[2] &
                     ~cs_n_f_reg;

    // shift on sclk rise while selected; frame ends on chip select release
    always @(posedge clk)
    begin
        if (rst | clamp)
        begin
            shift_reg       <= 16'h0000;
            count_reg       <= 5'h00;
            frame_valid_reg <= 1'b0;
            frame_word_reg  <= 16'h0000;
        end
        else
        begin
            frame_valid_reg <= 1'b0;
            if (cs_n_f_reg)
                count_reg <= 5'h00;
            if (!cs_n_f_reg && sclk_rise)
            begin
                shift_reg <= {shift_reg[14:0], din_f_reg};
                if (count_reg != 5'h1F)
                    count_reg <= count_reg + 5'h01;
            end
            // frames of any other length are dropped
            if (cs_rise && count_reg == `GCC_FRAME_BITS)
            begin
                frame_valid_reg <= 1'b1;
                frame_word_reg  <= shift_reg;
            end
        end
    end

endmodule // gcc_spi_rx
`default_nettype wire

/* File: gcc_top.v */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "gcc_defs.vh"

module gcc_top (
    input  wire        MCLK,
    input  wire        RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire        PREADY,
    output reg  [31:0] PRDATA,
    output wire        PSLVERR,
    input  wire        SCLK,
    input  wire        CS_N,
    input  wire        DIN,
    input  wire        ZC_IN_WINDOW,
    input  wire        ZC_TIMEOUT,
    input  wire        PWRUP_CLAMP,
    output wire        ZC_TIMER_RUN,
    output wire        INPUT_CLAMP,
    output reg  [5:0]  ATTEN_CODE,
    input  wire [3:0]  GENERAL_PURPOSE_OUTPUT_IN,
    output reg  [3:0]  GENERAL_PURPOSE_OUTPUT_OUT,
    output reg  [3:0]  GENERAL_PURPOSE_OUTPUT_OE
);

    localparam ST_IDLE = 1'b0;
    localparam ST_WAIT = 1'b1;

    reg  [2:0]  win_sync;
    reg  [2:0]  tmo_sync;
    reg  [2:0]  clamp_sync;
    reg  [2:0]  strap_s0;
    reg  [2:0]  strap_s1;
    reg  [2:0]  strap_s2;
    reg         win_reg;
    reg         tmo_reg;
    reg         clamp_reg;
    reg  [2:0]  chip_addr_reg;
    reg         zc_en_reg;
    reg         state_reg;
    reg         state_next;
    reg  [5:0]  pend_code_reg;
    reg  [5:0]  pend_code_next;
    reg  [5:0]  gain_next;
    reg  [3:0]  gpo_reg;
    reg         cmd_valid;
    reg  [5:0]  cmd_code;
    wire        frame_valid;
    wire [15:0] frame_word;

    // legal gain codes: zero or the one-step range
    function gain_ok;
        input [5:0] code;
        begin
            gain_ok = (code == `GCC_GAIN_MIN) ||
                      (code >= `GCC_GAIN_STEP_LO);
        end
    endfunction

    // register offset compare
    function is_ofs;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            is_ofs = (addr == ofs);
        end
    endfunction

    gcc_spi_rx u_rx (
        .clk             (MCLK),
        .rst             (RST),
        .clamp           (clamp_reg),
        .sclk_pin        (SCLK),
        .cs_n_pin        (CS_N),
        .din_pin         (DIN),
        .frame_valid_reg (frame_valid),
        .frame_word_reg  (frame_word)
    );

    // three-stage synchronisers for the analog-side and strap inputs
    always @(posedge MCLK)
    begin
        win_sync   <= {win_sync[1:0], ZC_IN_WINDOW};
        tmo_sync   <= {tmo_sync[1:0], ZC_TIMEOUT};
        clamp_sync <= {clamp_sync[1:0], PWRUP_CLAMP};
        strap_s0   <= GENERAL_PURPOSE_OUTPUT_IN[2:0];
        strap_s1   <= strap_s0;
        strap_s2   <= strap_s1;
    end

    // filtered levels; clamp defaults to active so nothing leaks at start
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            win_reg   <= 1'b0;
            tmo_reg   <= 1'b0;
            clamp_reg <= 1'b1;
        end
        else
        begin
            if (win_sync[1] == win_sync[2])
                win_reg <= win_sync[2];
            if (tmo_sync[1] == tmo_sync[2])
                tmo_reg <= tmo_sync[2];
            if (clamp_sync[1] == clamp_sync[2])
                clamp_reg <= clamp_sync[2];
        end
    end

    // address straps follow the pins all through reset, frozen at release
    always @(posedge MCLK)
    begin
        if (RST && strap_s1 == strap_s2)
            chip_addr_reg <= strap_s2;
    end

    // strap pins float while in reset, then all four are driven
    always @(posedge MCLK)
    begin
        if (RST)
        begin
            GENERAL_PURPOSE_OUTPUT_OE  <= 4'h0;
            GENERAL_PURPOSE_OUTPUT_OUT <= `GCC_GPO_RESET;
        end
        else
        begin
            GENERAL_PURPOSE_OUTPUT_OE  <= 4'hF;
            GENERAL_PURPOSE_OUTPUT_OUT <= gpo_reg;
        end
    end

    assign INPUT_CLAMP = clamp_reg;

    wire frame_hit = frame_valid && !clamp_reg &&
        (frame_word[`GCC_FR_ADDR_MSB:`GCC_FR_ADDR_LSB] == chip_addr_reg);
    wire [1:0] frame_cmd = frame_word[`GCC_FR_CMD_MSB:`GCC_FR_CMD_LSB];
    wire apb_wr  = PSEL && PENABLE && PWRITE;
    wire apb_acc = PSEL && PENABLE;

    // gain command from serial link, or from software when none arrives
    always @*
    begin
        cmd_valid = 1'b0;
        cmd_code  = frame_word[5:0];
        if (frame_hit && frame_cmd == `GCC_CMD_GAIN)
        begin
            cmd_valid = gain_ok(frame_word[5:0]);
        end
        else if (apb_wr && is_ofs(PADDR, `GCC_OFS_GAIN))
        begin
            cmd_code  = PWDATA[5:0];
            cmd_valid = gain_ok(PWDATA[5:0]);
        end
    end

    // gating machine; a new command in the apply cycle still wins
    always @*
    begin
        state_next     = state_reg;
        pend_code_next = pend_code_reg;
        gain_next      = ATTEN_CODE;
        case (state_reg)
            ST_IDLE:
            begin
                if (cmd_valid && !zc_en_reg)
                    gain_next = cmd_code;
                else if (cmd_valid)
                begin
                    pend_code_next = cmd_code;
                    state_next     = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (cmd_valid)
                begin
                    pend_code_next = cmd_code;
                    if (!zc_en_reg)
                    begin
                        gain_next  = cmd_code;
                        state_next = ST_IDLE;
                    end
                end
                else if (!zc_en_reg || win_reg || tmo_reg)
                begin
                    gain_next  = pend_code_reg;
                    state_next = ST_IDLE;
                end
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // external rc timer runs while a change is pending
    assign ZC_TIMER_RUN = (state_reg == ST_WAIT);

    always @(posedge MCLK)
    begin
        if (RST)
        begin
            state_reg     <= ST_IDLE;
            pend_code_reg <= `GCC_GAIN_RESET;
            ATTEN_CODE    <= `GCC_GAIN_RESET;
            zc_en_reg     <= `GCC_CTRL_RESET;
            gpo_reg       <= `GCC_GPO_RESET;
        end
        else
        begin
            state_reg     <= state_next;
            pend_code_reg <= pend_code_next;
            ATTEN_CODE    <= gain_next;
            if (apb_wr && is_ofs(PADDR, `GCC_OFS_CTRL))
                zc_en_reg <= PWDATA[`GCC_CTRL_ZC_BIT];
            // serial gpo command beats a same-cycle software write
            if (frame_hit && frame_cmd == `GCC_CMD_GPO)
                gpo_reg <= frame_word[3:0];
            else if (apb_wr && is_ofs(PADDR, `GCC_OFS_GPO))
                gpo_reg <= PWDATA[3:0];
        end
    end

    // zero-wait slave; unmapped offsets answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = apb_acc && !(is_ofs(PADDR, `GCC_OFS_CTRL) ||
                     is_ofs(PADDR, `GCC_OFS_GAIN) ||
                     is_ofs(PADDR, `GCC_OFS_GPO) ||
                     is_ofs(PADDR, `GCC_OFS_STATUS));

    // read data registered during setup, so valid in the access cycle
    always @(posedge MCLK)
    begin
        if (RST)
            PRDATA <= 32'h00000000;
        else if (PSEL && !PENABLE)
        begin
            PRDATA <= 32'h00000000;
            case (PADDR)
                `GCC_OFS_CTRL:   PRDATA[0] <= zc_en_reg;
                `GCC_OFS_GAIN:   PRDATA[5:0] <= ATTEN_CODE;
                `GCC_OFS_GPO:    PRDATA[3:0] <= gpo_reg;
                `GCC_OFS_STATUS:
                begin
                    PRDATA[`GCC_ST_GAIN_LSB+5:`GCC_ST_GAIN_LSB] <= ATTEN_CODE;
                    PRDATA[`GCC_ST_PEND_BIT] <= state_reg;
                    PRDATA[`GCC_ST_ADDR_LSB+2:`GCC_ST_ADDR_LSB] <=
                        chip_addr_reg;
                end
                default:         PRDATA <= 32'h00000000;
            endcase
        end
    end

endmodule // gcc_top
`default_nettype wire

/* File: gcc_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gcc_defs.vh"

module gcc_top_chk (
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic        CS_N,
    input wire logic        ZC_IN_WINDOW,
    input wire logic        ZC_TIMEOUT,
    input wire logic        PWRUP_CLAMP,
    input wire logic        ZC_TIMER_RUN,
    input wire logic        INPUT_CLAMP,
    input wire logic [5:0]  ATTEN_CODE,
    input wire logic [3:0]  GENERAL_PURPOSE_OUTPUT_OE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    // bus errors only inside an access cycle
    err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
        else $error("error outside access");
    // offsets above the status register refused with zero data
    err_unmapped_a: assert property (PSEL && PENABLE &&
        PADDR > `GCC_OFS_STATUS |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped access accepted");
    // codes one to seven never reach the attenuator
    gain_code_a: assert property (
        ATTEN_CODE == 6'h00 || ATTEN_CODE >= 6'h08)
        else $error("reserved gain code applied");
    // filter lag is covered by six quiet cycles before the check; the bus
    // must be quiet too, as a control write ends the wait one cycle late
    hold_pending_a: assert property (
        (!ZC_IN_WINDOW && !ZC_TIMEOUT && !PSEL)[*6] ##0 ZC_TIMER_RUN
        |=> ZC_TIMER_RUN)
        else $error("pending change left early");
    timeout_apply_a: assert property (
        ZC_TIMER_RUN && ZC_TIMEOUT |-> ##[1:6] !ZC_TIMER_RUN)
        else $error("timeout did not apply change");
    clamp_hold_a: assert property (
        PWRUP_CLAMP[*6] |-> INPUT_CLAMP)
        else $error("clamp not honoured");
    oe_drive_a: assert property (
        !$past(RST) |-> GENERAL_PURPOSE_OUTPUT_OE == 4'hF)
        else $error("outputs not driven");
    // a quiet link and bus with no change pending leave the applied gain alone
    gain_stable_a: assert property (
        (CS_N && !PSEL && !ZC_TIMER_RUN)[*8] |=> $stable(ATTEN_CODE))
        else $error("gain moved without command");
endmodule // gcc_top_chk

bind gcc_top gcc_top_chk chk (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .CS_N(CS_N), .ZC_IN_WINDOW(ZC_IN_WINDOW), .ZC_TIMEOUT(ZC_TIMEOUT),
    .PWRUP_CLAMP(PWRUP_CLAMP), .ZC_TIMER_RUN(ZC_TIMER_RUN),
    .INPUT_CLAMP(INPUT_CLAMP), .ATTEN_CODE(ATTEN_CODE),
    .GENERAL_PURPOSE_OUTPUT_OE(GENERAL_PURPOSE_OUTPUT_OE)
);

`default_nettype wire

/* File: gcc_spi_host.sv */
`timescale 1ns/100ps
`default_nettype none

// host end of the link; clock idles low between frames
module gcc_spi_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic din
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end

    // msb first; odd start offset keeps phase unrelated to MCLK
    task automatic send(input logic [15:0] w);
        #37 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            din = w[i];
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        din = ~din; // released line shows no stale bit
        #400;
    endtask
endmodule // gcc_spi_host

`default_nettype wire

/* File: tb_gcc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "gcc_defs.vh"

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("[FAIL] %0t got %h want %h", $time, got, exp); \
        end \
    end

module tb_gcc_top;
    logic        MCLK = 1'b0;
    logic        RST = 1'b1;
    logic        PSEL = 1'b0;
    logic        PENABLE = 1'b0;
    logic        PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h00000000;
    logic        ZC_IN_WINDOW = 1'b0;
    logic        ZC_TIMEOUT = 1'b0;
    logic        PWRUP_CLAMP = 1'b0;
    logic [3:0]  strap = 4'h0;
    logic [31:0] seed = 32'h00000FC8;
    logic [32:0] q[$];
    logic [32:0] exp_w;
    logic [2:0]  ad;
    logic [5:0]  c;
    int          n_mismatch = 0;
    int          num_checks = 0;
    wire         PREADY, PSLVERR, SCLK, CS_N, DIN;
    wire  [31:0] PRDATA;
    wire  [3:0]  gp_out, gp_oe, gp_pin;

    // straps win only where the pin is not driven
    assign gp_pin = (gp_out & gp_oe) | (strap & ~gp_oe);

    gcc_top dut (
        .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
        .PRDATA(PRDATA), .PSLVERR(PSLVERR), .SCLK(SCLK), .CS_N(CS_N),
        .DIN(DIN), .ZC_IN_WINDOW(ZC_IN_WINDOW), .ZC_TIMEOUT(ZC_TIMEOUT),
        .PWRUP_CLAMP(PWRUP_CLAMP), .ZC_TIMER_RUN(), .INPUT_CLAMP(),
        .ATTEN_CODE(), .GENERAL_PURPOSE_OUTPUT_IN(gp_pin),
        .GENERAL_PURPOSE_OUTPUT_OUT(gp_out),
        .GENERAL_PURPOSE_OUTPUT_OE(gp_oe)
    );

    gcc_spi_host host (
        .sclk(SCLK),
        .cs_n(CS_N),
        .din(DIN)
    );

    // 20 MHz system clock
    initial
        forever #25 MCLK = ~MCLK;

    task automatic summarize();
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one bus cycle; entered just after a rising edge
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do
            @(posedge MCLK);
        while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(a, 1'b0, 32'h00000000);
    endtask

    task automatic ser(input logic [15:0] w);
        host.send(w);
        repeat (10) @(posedge MCLK);
    endtask

    task automatic do_reset(input logic [2:0] a);
        RST <= 1'b1;
        strap <= {1'b0, a};
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
    endtask

    // xorshift, mapped onto the one-step codes only
    function automatic logic [5:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 6'h08 + 6'(seed % 32'h00000038);
    endfunction

    // each finished read is held against the oldest note
    always @(posedge MCLK)
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
        begin
            exp_w = q.pop_front();
            `CHK({PSLVERR, PRDATA}, exp_w)
            if (PADDR == `GCC_OFS_GPO)
                `CHK(gp_out, exp_w[3:0])
        end

    initial
    begin
        for (int a = 0; a < 8; a++)
        begin
            ad = 3'(a);
            do_reset(ad);
            rd(`GCC_OFS_STATUS, {18'h0, ad, 12'h000});
            c = rnd();
            ser({ad ^ 3'h1, 2'h0, 5'h00, c});
            rd(`GCC_OFS_GAIN, 33'h0);
            ser({ad, 2'h0, 5'h00, c});
            rd(`GCC_OFS_GAIN, {27'h0, c});
            ser({ad, 2'h1, 7'h00, c[3:0]});
            rd(`GCC_OFS_GPO, {29'h0, c[3:0]});
        end
        // large rises go in small steps so the servo can follow
        for (int s = 1; s <= 3; s++)
        begin
            c = 6'(8 + 3 * s);
            ser({ad, 2'h0, 5'h00, c});
            rd(`GCC_OFS_GAIN, {27'h0, c});
        end
        apb(`GCC_OFS_GPO, 1'b1, 32'h0000000A);
        rd(`GCC_OFS_GPO, {29'h0, 4'hA});
        // an unknown command must leave the gain alone
        ser({ad, 2'h2, 5'h00, 6'h3F});
        apb(`GCC_OFS_GAIN, 1'b1, 32'h00000005);
        rd(`GCC_OFS_GAIN, {27'h0, c});
        apb(`GCC_OFS_CTRL, 1'b1, 32'h00000001);
        ser({ad, 2'h0, 5'h00, rnd()});
        rd(`GCC_OFS_STATUS, {18'h0, ad, 3'h0, 1'b1, 2'h0, c});
        c = rnd();
        ser({ad, 2'h0, 5'h00, c});
        ZC_IN_WINDOW <= 1'b1;
        repeat (8) @(posedge MCLK);
        ZC_IN_WINDOW <= 1'b0;
        rd(`GCC_OFS_GAIN, {27'h0, c});
        c = rnd();
        ser({ad, 2'h0, 5'h00, c});
        ZC_TIMEOUT <= 1'b1;
        repeat (8) @(posedge MCLK);
        ZC_TIMEOUT <= 1'b0;
        rd(`GCC_OFS_GAIN, {27'h0, c});
        rd(12'h010, {1'b1, 32'h00000000});
        PWRUP_CLAMP <= 1'b1;
        repeat (8) @(posedge MCLK);
        ser({ad, 2'h0, 5'h00, rnd()});
        PWRUP_CLAMP <= 1'b0;
        repeat (8) @(posedge MCLK);
        rd(`GCC_OFS_STATUS, {18'h0, ad, 6'h00, c});
        summarize();
    end

    // run needs about 5000 cycles
    initial
    begin
        repeat (20000) @(posedge MCLK);
        n_mismatch++;
        summarize();
    end
endmodule // tb_gcc_top

`default_nettype wire
